// >>> prs_input_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs come from outside the clock domain
module prs_input_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] out_next;

    // stage one feeds stage two only
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else begin
            s1_reg  <= pinIn;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign pinOut = out_reg;
endmodule : prs_input_sync

// >>> prs_pkg.sv
// constants for the pll reference input select block
// assumes a 200 MHz register clock and 32-bit axi4-lite register access
package prs_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] SEL_INDEX    = 8'h32;
    localparam logic [7:0] CTL_INDEX    = 8'h33;
    localparam logic [7:0] STAT_INDEX   = 8'h34;
    localparam int         ADDR_W       = 10;
    localparam logic [9:0] SEL_ADDR     = {SEL_INDEX, 2'b00};
    localparam logic [9:0] CTL_ADDR     = {CTL_INDEX, 2'b00};
    localparam logic [9:0] STAT_ADDR    = {STAT_INDEX, 2'b00};
    localparam logic [23:0] RD_PAD      = 24'h00_0000;

    localparam int SEC_MODE_HI  = 7;
    localparam int SEC_MODE_LO  = 6;
    localparam int PRI_MODE_HI  = 5;
    localparam int PRI_MODE_LO  = 4;
    localparam int REFSRC_HI    = 1;
    localparam int REFSRC_LO    = 0;
    localparam int BYPASS_BIT   = 7;
    localparam int KEEP_ON_BIT  = 2;
    localparam int SEC_GAIN_BIT = 1;
    localparam int PRI_GAIN_BIT = 0;

    // sec mode 2, pri mode 1, reserved 1, ref select 1
    localparam logic [7:0] SEL_RESET = 8'h95;
    localparam logic [7:0] CTL_RESET = 8'h03;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_PERIOD_NS = 5;
    localparam int GUARD_NS      = 20;
    // least time, so round up
    localparam logic [2:0] GUARD_CYCLES =
        3'((GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        BUF_SINGLE = 2'b00,
        BUF_DIFF   = 2'b01,
        BUF_XTAL   = 2'b10,
        BUF_OFF    = 2'b11
    } prs_buf_mode_e;

    typedef enum logic [1:0] {
        REF_AUTO = 2'b00,
        REF_PIN  = 2'b01,
        REF_PRI  = 2'b10,
        REF_SEC  = 2'b11
    } prs_ref_src_e;

    typedef enum logic [1:0] {
        ST_PRI    = 2'b00,
        ST_TO_SEC = 2'b01,
        ST_SEC    = 2'b10,
        ST_TO_PRI = 2'b11
    } prs_state_e;
endpackage : prs_pkg

// >>> prs_ref_select.sv
// reference input configuration, selection and glitch-less switch control
// assumes an axi4-lite master and asynchronous pin and clock-valid inputs
module prs_ref_select
    import prs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              refPinAboveLow,
    input  wire logic              refPinAboveMid,
    input  wire logic              primaryValid,
    input  wire logic              secondaryValid,
    output logic [1:0]             secondaryBufferMode,
    output logic [1:0]             primaryBufferMode,
    output logic                   secondaryBufferEnable,
    output logic                   primaryBufferEnable,
    output logic                   secondaryBufferGain,
    output logic                   primaryBufferGain,
    output logic                   switchMuxBypass,
    output logic                   refSelSecondary,
    output logic                   refClockGate
);
    logic [3:0] syncPins;
    logic       pinAboveLow, pinAboveMid, priOk, secOk;

    prs_input_sync #(
        .WIDTH (4)
    ) u_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .pinIn  ({secondaryValid, primaryValid, refPinAboveMid, refPinAboveLow}),
        .pinOut (syncPins)
    );
    assign {secOk, priOk, pinAboveMid, pinAboveLow} = syncPins;

    // register bus state
    logic [7:0]        selReg_reg, selReg_next, ctlReg_reg, ctlReg_next;
    logic              awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
    logic [ADDR_W-1:0] awAddr_reg, awAddr_next;
    logic [7:0]        wData_reg, wData_next;
    logic              wStrb_reg, wStrb_next;
    logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic [7:0]        statusByte;
    logic              doWrite;

    // selection state
    prs_state_e        state_reg, state_next;
    logic [2:0]        guard_reg, guard_next;
    logic              refSec_reg, refSec_next, gate_reg, gate_next;
    logic              parked_reg, parked_next;
    logic              priEn_reg, priEn_next, secEn_reg, secEn_next;
    logic              autoMode, wantSec;
    prs_ref_src_e      refSrc;
    prs_buf_mode_e     secMode;

    assign awready = !awHeld_reg && !bvalid_reg;
    assign wready  = !wHeld_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign doWrite = awHeld_reg && wHeld_reg;
    assign statusByte = {2'b00, pinAboveMid, pinAboveLow, secOk, priOk,
                         !gate_reg, refSec_reg};

    always_comb begin
        selReg_next = selReg_reg;
        ctlReg_next = ctlReg_reg;
        awHeld_next = awHeld_reg;
        awAddr_next = awAddr_reg;
        wHeld_next  = wHeld_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (awvalid && awready) begin
            awHeld_next = 1'b1;
            awAddr_next = awaddr;
        end
        if (wvalid && wready) begin
            wHeld_next = 1'b1;
            wData_next = wdata[7:0];
            wStrb_next = wstrb[0];
        end
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            // byte lane 0 carries the whole register
            if (awAddr_reg == SEL_ADDR) begin
                if (wStrb_reg) begin
                    selReg_next = wData_reg;
                end
            end else if (awAddr_reg == CTL_ADDR) begin
                if (wStrb_reg) begin
                    ctlReg_next = wData_reg;
                end
            end else if (awAddr_reg == STAT_ADDR) begin
                bresp_next = RESP_OKAY;
            end else begin
                bresp_next = RESP_SLVERR;
            end
        end
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            if (araddr == SEL_ADDR) begin
                rdata_next = {RD_PAD, selReg_reg};
            end else if (araddr == CTL_ADDR) begin
                rdata_next = {RD_PAD, ctlReg_reg};
            end else if (araddr == STAT_ADDR) begin
                rdata_next = {RD_PAD, statusByte};
            end else begin
                rdata_next = '0;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            selReg_reg <= SEL_RESET;
            ctlReg_reg <= CTL_RESET;
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wHeld_reg  <= 1'b0;
            wData_reg  <= '0;
            wStrb_reg  <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else begin
            selReg_reg <= selReg_next;
            ctlReg_reg <= ctlReg_next;
            awHeld_reg <= awHeld_next;
            awAddr_reg <= awAddr_next;
            wHeld_reg  <= wHeld_next;
            wData_reg  <= wData_next;
            wStrb_reg  <= wStrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp  = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata  = rdata_reg;
    assign rresp  = rresp_reg;

    assign secondaryBufferMode = selReg_reg[SEC_MODE_HI:SEC_MODE_LO];
    assign primaryBufferMode   = selReg_reg[PRI_MODE_HI:PRI_MODE_LO];
    assign switchMuxBypass     = ctlReg_reg[BYPASS_BIT];
    assign secondaryBufferGain = ctlReg_reg[SEC_GAIN_BIT];
    assign primaryBufferGain   = ctlReg_reg[PRI_GAIN_BIT];
    assign refSrc  = prs_ref_src_e'(selReg_reg[REFSRC_HI:REFSRC_LO]);
    assign secMode = prs_buf_mode_e'(secondaryBufferMode);

    always_comb begin
        autoMode = 1'b0;
        wantSec  = refSec_reg;
        case (refSrc)
            REF_AUTO: autoMode = 1'b1;
            REF_PIN: begin
                // pin high hands over to automatic selection
                if (pinAboveMid) begin
                    autoMode = 1'b1;
                end else begin
                    wantSec = pinAboveLow;
                end
            end
            REF_PRI: wantSec = 1'b0;
            REF_SEC: wantSec = 1'b1;
            default: wantSec = refSec_reg;
        endcase
        // with both inputs lost, hold the current reference
        if (autoMode) begin
            wantSec = priOk ? 1'b0 : (secOk ? 1'b1 : refSec_reg);
        end
    end

    always_comb begin
        state_next  = state_reg;
        guard_next  = guard_reg;
        refSec_next = refSec_reg;
        gate_next   = gate_reg;
        parked_next = parked_reg;
        case (state_reg)
            ST_PRI: begin
                if (wantSec) begin
                    if (switchMuxBypass) begin
                        state_next  = ST_SEC;
                        refSec_next = 1'b1;
                        parked_next = 1'b0;
                    end else begin
                        state_next = ST_TO_SEC;
                        guard_next = GUARD_CYCLES - 3'd1;
                        gate_next  = 1'b0;
                    end
                end
            end
            ST_TO_SEC: begin
                if (guard_reg == '0) begin
                    state_next  = ST_SEC;
                    refSec_next = 1'b1;
                    gate_next   = 1'b1;
                    parked_next = 1'b0;
                end else begin
                    guard_next = guard_reg - 3'd1;
                end
            end
            ST_SEC: begin
                if (!wantSec) begin
                    if (switchMuxBypass) begin
                        state_next  = ST_PRI;
                        refSec_next = 1'b0;
                        parked_next = 1'b1;
                    end else begin
                        state_next = ST_TO_PRI;
                        guard_next = GUARD_CYCLES - 3'd1;
                        gate_next  = 1'b0;
                    end
                end
            end
            ST_TO_PRI: begin
                if (guard_reg == '0) begin
                    state_next  = ST_PRI;
                    refSec_next = 1'b0;
                    gate_next   = 1'b1;
                    parked_next = 1'b1;
                end else begin
                    guard_next = guard_reg - 3'd1;
                end
            end
            default: state_next = ST_PRI;
        endcase
        priEn_next = !primaryBufferMode[1];
        // parked crystal saves power but restarts slowly on the next failover
        secEn_next = (secMode != BUF_OFF) && !((secMode == BUF_XTAL)
                     && !ctlReg_reg[KEEP_ON_BIT] && parked_reg && !refSec_reg);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg  <= ST_PRI;
            guard_reg  <= '0;
            refSec_reg <= 1'b0;
            gate_reg   <= 1'b1;
            parked_reg <= 1'b0;
            priEn_reg  <= 1'b0;
            secEn_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            guard_reg  <= guard_next;
            refSec_reg <= refSec_next;
            gate_reg   <= gate_next;
            parked_reg <= parked_next;
            priEn_reg  <= priEn_next;
            secEn_reg  <= secEn_next;
        end
    end

    assign refSelSecondary       = refSec_reg;
    assign refClockGate          = gate_reg;
    assign primaryBufferEnable   = priEn_reg;
    assign secondaryBufferEnable = secEn_reg;

    property p_sec_mode_rst;
        @(posedge clock) disable iff (!rst_n)
        !$past(rst_n) |-> secondaryBufferMode == SEL_RESET[SEC_MODE_HI:SEC_MODE_LO];
    endproperty
    a_sec_mode_rst: assert property (p_sec_mode_rst)
        else $error("secondary mode not crystal after reset");

    property p_pri_off;
        @(posedge clock) disable iff (!rst_n)
        primaryBufferMode[1] |=> !primaryBufferEnable;
    endproperty
    a_pri_off: assert property (p_pri_off)
        else $error("primary buffer enabled in a disabled mode");

    property p_ref_rst;
        @(posedge clock) disable iff (!rst_n)
        !$past(rst_n) |-> refSrc == REF_PIN && primaryBufferMode == BUF_DIFF;
    endproperty
    a_ref_rst: assert property (p_ref_rst)
        else $error("reference select not pin mode after reset");

    property p_pin_low;
        @(posedge clock) disable iff (!rst_n)
        (refSrc == REF_PIN && !pinAboveLow && !pinAboveMid && state_reg == ST_SEC
         && !switchMuxBypass) |=> state_reg == ST_TO_PRI;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("pin low did not start return to primary");

    property p_bypass;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_PRI && wantSec && switchMuxBypass)
            |=> refSelSecondary && refClockGate;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypassed switch was not immediate");

    property p_xtal_park;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_TO_PRI && guard_reg == '0 && secMode == BUF_XTAL
         && !ctlReg_reg[KEEP_ON_BIT] && !doWrite) |=> ##1 !secondaryBufferEnable;
    endproperty
    a_xtal_park: assert property (p_xtal_park)
        else $error("crystal buffer left on after return");

    property p_sec_gain;
        @(posedge clock) disable iff (!rst_n)
        (doWrite && wStrb_reg && awAddr_reg == CTL_ADDR)
            |=> secondaryBufferGain == $past(wData_reg[SEC_GAIN_BIT]);
    endproperty
    a_sec_gain: assert property (p_sec_gain)
        else $error("secondary gain not taken from write");

    property p_pri_gain;
        @(posedge clock) disable iff (!rst_n)
        (doWrite && wStrb_reg && awAddr_reg == CTL_ADDR)
            |=> primaryBufferGain == $past(wData_reg[PRI_GAIN_BIT]);
    endproperty
    a_pri_gain: assert property (p_pri_gain)
        else $error("primary gain not taken from write");

    property p_glitchless;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_PRI && wantSec && !switchMuxBypass)
            |=> !refClockGate [*4] ##1 (refSelSecondary && refClockGate);
    endproperty
    a_glitchless: assert property (p_glitchless)
        else $error("switch to secondary not gated for four cycles");
endmodule : prs_ref_select

// >>> prs_ref_select_tb.sv
// self-checking bench for the reference input select block
// assumes the bench alone drives every port; no partner model is needed
module tb
    import prs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clock;
    logic              rst_n;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    logic              refPinAboveLow;
    logic              refPinAboveMid;
    logic              primaryValid;
    logic              secondaryValid;
    logic [1:0]        secondaryBufferMode;
    logic [1:0]        primaryBufferMode;
    logic              secondaryBufferEnable;
    logic              primaryBufferEnable;
    logic              secondaryBufferGain;
    logic              primaryBufferGain;
    logic              switchMuxBypass;
    logic              refSelSecondary;
    logic              refClockGate;
    int                bad_count;
    int                n_tests;
    logic [1:0]        resp;
    logic [31:0]       rd;
    int                gateLow;

    prs_ref_select dut_u (
        .clock(clock), .rst_n(rst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .refPinAboveLow(refPinAboveLow), .refPinAboveMid(refPinAboveMid),
        .primaryValid(primaryValid), .secondaryValid(secondaryValid),
        .secondaryBufferMode(secondaryBufferMode), .primaryBufferMode(primaryBufferMode),
        .secondaryBufferEnable(secondaryBufferEnable),
        .primaryBufferEnable(primaryBufferEnable),
        .secondaryBufferGain(secondaryBufferGain), .primaryBufferGain(primaryBufferGain),
        .switchMuxBypass(switchMuxBypass), .refSelSecondary(refSelSecondary),
        .refClockGate(refClockGate)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic timed_out(input string what);
        $display("MISMATCH %s expected handshake seen none", what);
        bad_count++;
        close_out();
    endtask : timed_out

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask : chk

    // both channels offered together, each released at its own edge
    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
        bit awDone;
        bit wDone;
        int i;
        awDone = 0;
        wDone = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'h1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50 && !(awDone && wDone); i++) begin
            @(posedge clock);
            if (!awDone && awready) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        if (!(awDone && wDone)) timed_out("write address or data");
        for (i = 0; i < 50 && !bvalid; i++) @(posedge clock);
        if (!bvalid) timed_out("write response");
        r = bresp;
        // bready left high so back-to-back calls never drive it twice in one step
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (arready) break;
        end
        if (!arready) timed_out("read address");
        arvalid <= 1'b0;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (rvalid) break;
        end
        if (!rvalid) timed_out("read data");
        d = rdata;
        r = rresp;
    endtask : bus_rd

    // waits for the reference to settle, counting quiet cycles of the switch
    task automatic wait_ref(input string name, input logic exp, input int gateExp);
        int i;
        gateLow = 0;
        for (i = 0; i < 80; i++) begin
            @(posedge clock);
            if (refClockGate === 1'b0) gateLow++;
            if (refSelSecondary === exp && refClockGate === 1'b1) break;
        end
        chk(name, 32'(refSelSecondary), 32'(exp));
        chk({name, " quiet cycles"}, 32'(gateLow), 32'(gateExp));
    endtask : wait_ref

    task automatic s_reset;
        bus_rd(SEL_ADDR, rd, resp);
        chk("select reset", rd, {24'h00_0000, 2'h2, 2'h1, 2'h1, 2'h1});
        bus_rd(CTL_ADDR, rd, resp);
        chk("control reset", rd, 32'h0000_0003);
        chk("secondary mode out", 32'(secondaryBufferMode), 32'h0000_0002);
        chk("primary mode out", 32'(primaryBufferMode), 32'h0000_0001);
        chk("gains out", {30'h0, secondaryBufferGain, primaryBufferGain}, 32'h3);
        chk("bypass out", 32'(switchMuxBypass), 32'h0000_0000);
        chk("reference and enables", {28'h000_0000, refSelSecondary, refClockGate,
            secondaryBufferEnable, primaryBufferEnable}, 32'h0000_0007);
    endtask : s_reset

    task automatic s_modes;
        for (int m = 0; m < 4; m++) begin
            bus_wr(SEL_ADDR, 32'((m << 6) | (m << 4) | 5), resp);
            repeat (2) @(posedge clock);
            chk("secondary mode out", 32'(secondaryBufferMode), 32'(m));
            chk("primary mode out", 32'(primaryBufferMode), 32'(m));
            chk("primary enable", 32'(primaryBufferEnable), 32'(m < 2));
            chk("secondary enable", 32'(secondaryBufferEnable), 32'(m != 3));
            bus_rd(SEL_ADDR, rd, resp);
            chk("select readback", rd, 32'((m << 6) | (m << 4) | 5));
        end
        bus_wr(SEL_ADDR, 32'h0000_0095, resp);
    endtask : s_modes

    task automatic s_ctl;
        logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h07};
        foreach (vals[k]) begin
            bus_wr(CTL_ADDR, 32'(vals[k]), resp);
            @(posedge clock);
            chk("primary gain", 32'(primaryBufferGain), 32'(vals[k][0]));
            chk("secondary gain", 32'(secondaryBufferGain), 32'(vals[k][1]));
            chk("bypass", 32'(switchMuxBypass), 32'(vals[k][7]));
            bus_rd(CTL_ADDR, rd, resp);
            chk("control readback", rd, 32'(vals[k]));
        end
        bus_wr(CTL_ADDR, 32'h0000_0003, resp);
    endtask : s_ctl

    task automatic s_pin;
        primaryValid <= 1'b1;
        secondaryValid <= 1'b1;
        wait_ref("pin low", 1'b0, 0);
        refPinAboveLow <= 1'b1;
        wait_ref("pin mid", 1'b1, 4);
        refPinAboveLow <= 1'b0;
        wait_ref("pin back low", 1'b0, 4);
        refPinAboveLow <= 1'b1;
        wait_ref("pin mid again", 1'b1, 4);
        refPinAboveMid <= 1'b1;
        wait_ref("pin high auto", 1'b0, 4);
    endtask : s_pin

    task automatic s_force;
        bus_wr(SEL_ADDR, 32'h0000_0097, resp);
        wait_ref("forced secondary", 1'b1, 4);
        bus_wr(SEL_ADDR, 32'h0000_0096, resp);
        wait_ref("forced primary", 1'b0, 4);
        bus_wr(SEL_ADDR, 32'h0000_0094, resp);
        primaryValid <= 1'b0;
        wait_ref("auto failover", 1'b1, 4);
        @(posedge clock);
        chk("crystal stays on", 32'(secondaryBufferEnable), 32'h0000_0001);
        primaryValid <= 1'b1;
        wait_ref("auto return", 1'b0, 4);
        repeat (2) @(posedge clock);
        chk("crystal parked", 32'(secondaryBufferEnable), 32'h0000_0000);
        bus_wr(CTL_ADDR, 32'h0000_0087, resp);
        primaryValid <= 1'b0;
        wait_ref("bypassed failover", 1'b1, 0);
        primaryValid <= 1'b1;
        wait_ref("bypassed return", 1'b0, 0);
        repeat (2) @(posedge clock);
        chk("crystal kept on", 32'(secondaryBufferEnable), 32'h0000_0001);
    endtask : s_force

    task automatic s_unmapped;
        bus_wr(STAT_ADDR, 32'h0000_00FF, resp);
        chk("status write resp", 32'(resp), 32'(RESP_OKAY));
        bus_rd(STAT_ADDR, rd, resp);
        chk("status read resp", 32'(resp), 32'(RESP_OKAY));
        chk("status read", rd, 32'h0000_003C);
        bus_wr(10'h000, 32'h0000_00FF, resp);
        chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
        bus_rd(10'h000, rd, resp);
        chk("unmapped read resp", 32'(resp), 32'(RESP_SLVERR));
        chk("unmapped read data", rd, 32'h0000_0000);
    endtask : s_unmapped

    initial begin
        bad_count = 0;
        n_tests = 0;
        rd = 32'h0000_0000;
        rst_n = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        refPinAboveLow = 1'b0;
        refPinAboveMid = 1'b0;
        primaryValid = 1'b0;
        secondaryValid = 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        s_reset();
        s_modes();
        s_ctl();
        s_pin();
        s_force();
        s_unmapped();
        close_out();
    end
endmodule : tb
